// ---- hdl/ddrc_pkg.sv ----
// Constants and types shared by the half-rate controller front end
package ddrc_pkg;
    // Memory geometry
    localparam int MEM_ADDR_W = 13;
    localparam int BANK_W = 3;
    localparam int RANK_N = 2;
    localparam int NBANK = 16;
    localparam int BIDX_W = 4;
    localparam int CS_W = 4;
    // Local side: data four times the DQ width
    localparam int LDATA_W = 32;
    localparam int LBE_W = 4;
    localparam int LADDR_W = 25;
    localparam int COL_W = 8;
    localparam int RANK_BIT = 24;
    localparam int BANK_LSB = 21;
    localparam int ROW_LSB = 8;
    localparam int COL_LSB = 2;
    localparam int A10_AP = 10;
    localparam int A12_BL = 12;
    // Command entry layout
    localparam int E_WR = 25;
    localparam int E_LEN2 = 26;
    localparam int E_AP = 27;
    localparam int ENTRY_W = 28;
    // Queues
    localparam int CFIFO_DEPTH = 4;
    localparam int CPTR_W = 3;
    localparam int WFIFO_DEPTH = 8;
    localparam int WPTR_W = 4;
    localparam int WENTRY_W = 36;
    // Latency pipe and burst-chop wait
    localparam int LAT_W = 5;
    localparam int WPIPE_LEN = 32;
    localparam logic [1:0] GAP_CYC = 2'h2;
    // Phase pairs, bit 0 goes out first
    localparam logic [1:0] PH_ON = 2'h3;
    localparam logic [1:0] PH_OFF = 2'h0;
    localparam logic [1:0] PH_LEAD = 2'h2;
    // Chip select patterns
    localparam logic [3:0] CS_NONE = 4'hf;
    localparam logic [3:0] CS_ALL = 4'h0;
    localparam logic [3:0] CS_RANK0 = 4'hc;
    localparam logic [3:0] CS_RANK1 = 4'h3;
    // Commands as {ras_n, cas_n, we_n}
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_PCH = 3'h2;
    localparam logic [2:0] CMD_REF = 3'h1;
    typedef enum logic [4:0] {
        S_IDLE = 5'h01,
        S_RD = 5'h02,
        S_TAIL = 5'h04,
        S_GAP = 5'h08,
        S_REF = 5'h10
    } ddrc_state_t;
endpackage

// ---- hdl/ddrc_bank.sv ----
// Open-row tracker, one entry per bank of every rank
`timescale 1ns/1ns
module ddrc_bank (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Lookup and update
    input wire logic [ddrc_pkg::BIDX_W-1:0] idx,
    input wire logic [ddrc_pkg::MEM_ADDR_W-1:0] row,
    input wire logic act,
    input wire logic close,
    input wire logic close_all,
    // State
    output logic is_open,
    output logic row_hit,
    output logic any_open
);
    typedef struct packed {
        logic [ddrc_pkg::NBANK-1:0] open;
        logic [ddrc_pkg::NBANK-1:0][ddrc_pkg::MEM_ADDR_W-1:0] row;
    } ddrc_bank_t;

    ddrc_bank_t r;
    ddrc_bank_t n;

    always_comb begin
        n = r;
        if (close_all) begin
            n.open = '0;
        end else begin
            if (act) begin
                n.open[idx] = 1'b1;
                n.row[idx] = row;
            end
            if (close) begin
                n.open[idx] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    assign is_open = r.open[idx];
    assign row_hit = r.row[idx] == row;
    assign any_open = |r.open;
endmodule // ddrc_bank

// ---- hdl/ddrc_ctrl.sv ----
// Half-rate DDR3 controller front end with PHY handshake
// Function
// - Half-rate pins carry two phase bits
// - PHY times postamble from read-in-progress
// - PHY reports fixed read latency
// - Read valid has one bit per phase
// - PHY reports write latency to strobe
// - Write latency fixed after calibration
// - Phase bit zero goes out first
// - One memory access per local request
// - Size one chops to four, waits two
// - One open row per bank
// - Banks close on auto-precharge, row miss and refresh
// - Commands issue in acceptance order
// - Command queue holds four entries
// - Ready drops while command queue full, except for a memory-mapped second write beat
// - Native mode requests each write beat
// - Deeper write queue with beat count
// - Bank state drives precharge and activate
// - Read valid echoes read-in-progress delayed
// - Calibrate after reset, soft reset restarts
`timescale 1ns/1ns
module ddrc_ctrl (
    // Clock, reset and enable
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Configuration
    input wire logic native_mode,
    input wire logic partial_wdv_off,
    // User requests
    input wire logic local_read_req,
    input wire logic local_write_req,
    input wire logic [ddrc_pkg::LADDR_W-1:0] local_addr,
    input wire logic [1:0] local_size,
    input wire logic local_autopch,
    input wire logic [ddrc_pkg::LDATA_W-1:0] local_wdata,
    input wire logic [ddrc_pkg::LBE_W-1:0] local_be,
    output logic local_ready,
    output logic local_wdata_req,
    output logic [ddrc_pkg::LDATA_W-1:0] local_rdata,
    output logic local_rdata_valid,
    output logic local_rd_busy,
    // Refresh
    input wire logic refresh_req,
    output logic refresh_ack,
    // Calibration
    input wire logic cal_success,
    input wire logic cal_fail,
    input wire logic cal_restart,
    input wire logic [ddrc_pkg::LAT_W-1:0] wlat,
    output logic soft_reset_n,
    // Command to PHY
    output logic [ddrc_pkg::CS_W-1:0] phy_cs_n,
    output logic [1:0] phy_ras_n,
    output logic [1:0] phy_cas_n,
    output logic [1:0] phy_we_n,
    output logic [2*ddrc_pkg::BANK_W-1:0] phy_ba,
    output logic [2*ddrc_pkg::MEM_ADDR_W-1:0] phy_addr,
    // Data handshake with PHY
    output logic [1:0] phy_doing_rd,
    output logic [1:0] phy_dqs_burst,
    output logic [1:0] phy_wdata_valid,
    output logic [ddrc_pkg::LDATA_W-1:0] phy_wdata,
    output logic [ddrc_pkg::LBE_W-1:0] phy_dm,
    input wire logic [ddrc_pkg::LDATA_W-1:0] phy_rdata,
    input wire logic [1:0] phy_rdata_valid
);
    typedef struct packed {
        ddrc_pkg::ddrc_state_t st;
        logic [1:0] gap;
        logic cur_wr;
        logic [ddrc_pkg::CFIFO_DEPTH-1:0][ddrc_pkg::ENTRY_W-1:0] cmem;
        logic [ddrc_pkg::CPTR_W-1:0] cwp;
        logic [ddrc_pkg::CPTR_W-1:0] crp;
        logic [ddrc_pkg::WFIFO_DEPTH-1:0][ddrc_pkg::WENTRY_W-1:0] wmem;
        logic [ddrc_pkg::WPTR_W-1:0] wwp;
        logic [ddrc_pkg::WPTR_W-1:0] wrp;
        logic [ddrc_pkg::WPTR_W-1:0] claimed;
        logic [ddrc_pkg::WPTR_W-1:0] owed;
        logic reqd;
        logic mm_more;
        logic [ddrc_pkg::WPIPE_LEN-1:0] wpipe;
        logic [ddrc_pkg::WPIPE_LEN-1:0] lpipe;
        logic [1:0] wleft;
        logic [ddrc_pkg::WPTR_W-1:0] rd_words;
        logic [ddrc_pkg::CS_W-1:0] cs_n;
        logic [1:0] ras_n;
        logic [1:0] cas_n;
        logic [1:0] we_n;
        logic [2*ddrc_pkg::BANK_W-1:0] ba;
        logic [2*ddrc_pkg::MEM_ADDR_W-1:0] addr;
        logic [1:0] doing_rd;
        logic [1:0] dqs;
        logic [1:0] wdv;
        logic [ddrc_pkg::LDATA_W-1:0] wdata;
        logic [ddrc_pkg::LBE_W-1:0] dm;
        logic [ddrc_pkg::LDATA_W-1:0] rdata;
        logic rvalid;
        logic ref_ack;
        logic soft_reset_n;
    } ddrc_ctrl_t;

    ddrc_ctrl_t r;
    ddrc_ctrl_t n;

    logic [ddrc_pkg::CPTR_W-1:0] ccount;
    logic cfull;
    logic cvalid;
    logic [ddrc_pkg::ENTRY_W-1:0] head;
    logic [ddrc_pkg::WPTR_W-1:0] wcount;
    logic [ddrc_pkg::WPTR_W-1:0] wavail;
    logic [ddrc_pkg::WPTR_W-1:0] need;
    logic wfull;
    logic mm_beat;
    logic new_req;
    logic accept;
    logic wpush;
    logic wact;
    logic tap;
    logic tlen2;
    logic cal_ok;
    logic [ddrc_pkg::BIDX_W-1:0] bidx;
    logic [ddrc_pkg::MEM_ADDR_W-1:0] hrow;
    logic is_open;
    logic row_hit;
    logic any_open;
    logic act_bank;
    logic close_bank;
    logic close_all;
    logic issue_wr;
    logic issue_rd;
    logic pop;
    logic [ddrc_pkg::WENTRY_W-1:0] whead;

    // Queue status; one entry pops per issued access, so order holds
    assign ccount = ddrc_pkg::CPTR_W'(r.cwp - r.crp);
    assign cfull = ccount == ddrc_pkg::CPTR_W'(ddrc_pkg::CFIFO_DEPTH);
    assign cvalid = ccount != '0;
    assign head = r.cmem[r.crp[1:0]];
    assign wcount = ddrc_pkg::WPTR_W'(r.wwp - r.wrp);
    assign wfull = wcount == ddrc_pkg::WPTR_W'(ddrc_pkg::WFIFO_DEPTH);
    assign wavail = ddrc_pkg::WPTR_W'(wcount - r.claimed);
    assign need = head[ddrc_pkg::E_LEN2] ? 4'h2 : 4'h1;
    assign whead = r.wmem[r.wrp[2:0]];
    assign cal_ok = cal_success && !cal_fail;
    assign bidx = {head[ddrc_pkg::RANK_BIT], head[ddrc_pkg::BANK_LSB +: ddrc_pkg::BANK_W]};
    assign hrow = head[ddrc_pkg::ROW_LSB +: ddrc_pkg::MEM_ADDR_W];

    // A memory-mapped write of size two brings its second beat later
    assign mm_beat = !native_mode && r.mm_more && local_write_req;
    assign new_req = (local_read_req || local_write_req) && !mm_beat;
    assign accept = new_req && local_ready;

    always_comb begin
        if (mm_beat) begin
            local_ready = !wfull;
        end else begin
            local_ready = !cfull && (native_mode || !local_write_req || !wfull);
        end
    end

    // Count in-flight requests so the queue cannot overrun
    assign local_wdata_req = r.owed != '0
        && ddrc_pkg::WPTR_W'(wcount + {3'h0, r.reqd}) < ddrc_pkg::WPTR_W'(ddrc_pkg::WFIFO_DEPTH);
    assign wpush = native_mode ? r.reqd : (local_ready && local_write_req);

    // Strobe start taps the issue history at the advertised write latency
    assign tap = wlat != '0 && r.wpipe[ddrc_pkg::LAT_W'(wlat - 5'h1)];
    assign tlen2 = wlat != '0 && r.lpipe[ddrc_pkg::LAT_W'(wlat - 5'h1)];
    assign wact = r.wleft != 2'h0;

    ddrc_bank u_bank (
        .clk(clk),
        .reset(reset),
        .ce(ce),
        .idx(bidx),
        .row(hrow),
        .act(act_bank),
        .close(close_bank),
        .close_all(close_all),
        .is_open(is_open),
        .row_hit(row_hit),
        .any_open(any_open)
    );

    always_comb begin
        logic [2:0] cmd;
        logic [ddrc_pkg::MEM_ADDR_W-1:0] a;
        logic [ddrc_pkg::BANK_W-1:0] b;
        logic [ddrc_pkg::CS_W-1:0] cs;
        cmd = ddrc_pkg::CMD_NOP;
        a = r.addr[ddrc_pkg::MEM_ADDR_W-1:0];
        b = head[ddrc_pkg::BANK_LSB +: ddrc_pkg::BANK_W];
        cs = ddrc_pkg::CS_NONE;
        n = r;
        act_bank = 1'b0;
        close_bank = 1'b0;
        close_all = 1'b0;
        issue_wr = 1'b0;
        issue_rd = 1'b0;
        pop = 1'b0;
        n.doing_rd = ddrc_pkg::PH_OFF;
        n.ref_ack = 1'b0;
        unique case (r.st)
            ddrc_pkg::S_IDLE: begin
                if (!cal_ok) begin
                    cmd = ddrc_pkg::CMD_NOP;
                end else if (refresh_req) begin
                    cmd = ddrc_pkg::CMD_PCH;
                    a = '0;
                    a[ddrc_pkg::A10_AP] = 1'b1;
                    cs = ddrc_pkg::CS_ALL;
                    close_all = 1'b1;
                    n.st = ddrc_pkg::S_REF;
                end else if (cvalid) begin
                    if (!is_open) begin
                        cmd = ddrc_pkg::CMD_ACT;
                        a = hrow;
                        act_bank = 1'b1;
                    end else if (!row_hit) begin
                        cmd = ddrc_pkg::CMD_PCH;
                        a[ddrc_pkg::A10_AP] = 1'b0;
                        close_bank = 1'b1;
                    end else if (!head[ddrc_pkg::E_WR]) begin
                        n.doing_rd = ddrc_pkg::PH_ON;
                        n.st = ddrc_pkg::S_RD;
                    end else if (wavail >= need) begin
                        cmd = ddrc_pkg::CMD_WR;
                        issue_wr = 1'b1;
                    end
                    if (cmd != ddrc_pkg::CMD_PCH) begin
                        cs = head[ddrc_pkg::RANK_BIT] ? ddrc_pkg::CS_RANK1 : ddrc_pkg::CS_RANK0;
                    end else begin
                        cs = head[ddrc_pkg::RANK_BIT] ? ddrc_pkg::CS_RANK1 : ddrc_pkg::CS_RANK0;
                    end
                    if (cmd == ddrc_pkg::CMD_NOP) begin
                        cs = ddrc_pkg::CS_NONE;
                    end
                end
            end
            ddrc_pkg::S_RD: begin
                cmd = ddrc_pkg::CMD_RD;
                cs = head[ddrc_pkg::RANK_BIT] ? ddrc_pkg::CS_RANK1 : ddrc_pkg::CS_RANK0;
                n.doing_rd = ddrc_pkg::PH_ON;
                issue_rd = 1'b1;
            end
            ddrc_pkg::S_TAIL: begin
                // Second controller clock of an eight-beat burst
                n.doing_rd = r.cur_wr ? ddrc_pkg::PH_OFF : ddrc_pkg::PH_ON;
                n.st = ddrc_pkg::S_IDLE;
            end
            ddrc_pkg::S_GAP: begin
                n.gap = r.gap - 2'h1;
                if (r.gap == 2'h1) begin
                    n.st = ddrc_pkg::S_IDLE;
                end
            end
            ddrc_pkg::S_REF: begin
                cmd = ddrc_pkg::CMD_REF;
                cs = ddrc_pkg::CS_ALL;
                n.ref_ack = 1'b1;
                n.st = ddrc_pkg::S_IDLE;
            end
            default: begin
                n.st = ddrc_pkg::S_IDLE;
            end
        endcase

        // Read or write column phase
        if (issue_rd || issue_wr) begin
            a = '0;
            a[ddrc_pkg::COL_LSB +: ddrc_pkg::COL_W] = head[ddrc_pkg::COL_W-1:0];
            a[ddrc_pkg::A10_AP] = head[ddrc_pkg::E_AP];
            a[ddrc_pkg::A12_BL] = head[ddrc_pkg::E_LEN2];
            close_bank = head[ddrc_pkg::E_AP];
            pop = 1'b1;
            n.cur_wr = issue_wr;
            n.gap = ddrc_pkg::GAP_CYC;
            n.st = head[ddrc_pkg::E_LEN2] ? ddrc_pkg::S_TAIL : ddrc_pkg::S_GAP;
        end

        // Both phase bits identical on every pin
        n.cs_n = cs;
        n.ras_n = {2{cmd[2]}};
        n.cas_n = {2{cmd[1]}};
        n.we_n = {2{cmd[0]}};
        n.ba = {b, b};
        n.addr = {a, a};

        // Command queue
        if (accept) begin
            n.cmem[r.cwp[1:0]] = {local_autopch, local_size[1], local_write_req, local_addr};
            n.cwp = r.cwp + 3'h1;
        end
        if (pop) begin
            n.crp = r.crp + 3'h1;
        end

        // Write beat sourcing
        if (!native_mode) begin
            if (accept && local_write_req) begin
                n.mm_more = local_size[1];
            end else if (mm_beat && local_ready) begin
                n.mm_more = 1'b0;
            end
        end
        n.owed = ddrc_pkg::WPTR_W'(r.owed
            + ((native_mode && accept && local_write_req) ? {2'h0, local_size} : 4'h0)
            - {3'h0, local_wdata_req});
        n.reqd = local_wdata_req;
        if (wpush) begin
            n.wmem[r.wwp[2:0]] = {~local_be, local_wdata};
            n.wwp = r.wwp + 4'h1;
        end

        // Write data to PHY, strobe leads write-valid by one phase
        n.wpipe = {r.wpipe[ddrc_pkg::WPIPE_LEN-2:0], issue_wr};
        n.lpipe = {r.lpipe[ddrc_pkg::WPIPE_LEN-2:0], issue_wr && head[ddrc_pkg::E_LEN2]};
        n.wleft = 2'((wact ? r.wleft - 2'h1 : 2'h0) + (tap ? (tlen2 ? 2'h2 : 2'h1) : 2'h0));
        n.dqs = wact ? ddrc_pkg::PH_ON : (tap ? ddrc_pkg::PH_LEAD : ddrc_pkg::PH_OFF);
        n.wdv = ddrc_pkg::PH_OFF;
        if (wact) begin
            n.wdata = whead[ddrc_pkg::LDATA_W-1:0];
            n.dm = whead[ddrc_pkg::WENTRY_W-1 -: ddrc_pkg::LBE_W];
            n.wdv[1] = !(partial_wdv_off && &whead[ddrc_pkg::WENTRY_W-1 -: 2]);
            n.wdv[0] = !(partial_wdv_off && &whead[ddrc_pkg::LDATA_W +: 2]);
            n.wrp = r.wrp + 4'h1;
        end
        n.claimed = ddrc_pkg::WPTR_W'(r.claimed + (issue_wr ? need : 4'h0) - {3'h0, wact});

        // Read return, taken on the PHY's per-phase valid flags
        n.rvalid = phy_rdata_valid == ddrc_pkg::PH_ON;
        n.rdata = phy_rdata;
        n.rd_words = ddrc_pkg::WPTR_W'(r.rd_words + (issue_rd ? need : 4'h0)
            - {3'h0, r.rvalid && r.rd_words != '0});
        n.soft_reset_n = !cal_restart;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            r <= '0;
            r.st <= ddrc_pkg::S_IDLE;
            r.cs_n <= ddrc_pkg::CS_NONE;
            r.ras_n <= 2'h3;
            r.cas_n <= 2'h3;
            r.we_n <= 2'h3;
            r.soft_reset_n <= 1'b1;
        end else if (ce) begin
            r <= n;
        end
    end

    assign local_rdata = r.rdata;
    assign local_rdata_valid = r.rvalid;
    assign local_rd_busy = r.rd_words != '0;
    assign refresh_ack = r.ref_ack;
    assign soft_reset_n = r.soft_reset_n;
    assign phy_cs_n = r.cs_n;
    assign phy_ras_n = r.ras_n;
    assign phy_cas_n = r.cas_n;
    assign phy_we_n = r.we_n;
    assign phy_ba = r.ba;
    assign phy_addr = r.addr;
    assign phy_doing_rd = r.doing_rd;
    assign phy_dqs_burst = r.dqs;
    assign phy_wdata_valid = r.wdv;
    assign phy_wdata = r.wdata;
    assign phy_dm = r.dm;

    logic rw_out;
    logic rd_out;
    logic ref_out;
    assign rw_out = r.cs_n != ddrc_pkg::CS_NONE && r.ras_n == 2'h3 && r.cas_n == 2'h0;
    assign rd_out = rw_out && r.we_n == 2'h3;
    assign ref_out = r.cs_n != ddrc_pkg::CS_NONE && r.ras_n == 2'h0 && r.cas_n == 2'h0
        && r.we_n == 2'h3;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    ready_full_a: assert property (ce && cfull && !mm_beat |-> !local_ready)
        else $error("ready high with full command queue");
    cmd_depth_a: assert property (ccount <= 3'h4)
        else $error("command queue over four entries");
    cs_2t_a: assert property (r.cs_n[0] == r.cs_n[1] && r.cs_n[2] == r.cs_n[3]
        && r.ras_n[0] == r.ras_n[1] && r.we_n[0] == r.we_n[1])
        else $error("phase bits differ on a command pin");
    addr_dup_a: assert property (r.addr[12:0] == r.addr[25:13])
        else $error("address halves differ");
    rd_lead_a: assert property (rd_out |-> $past(r.doing_rd) == 2'h3 && r.doing_rd == 2'h3)
        else $error("read without leading read-in-progress");
    uncal_cmd_a: assert property (r.cs_n != ddrc_pkg::CS_NONE |-> $past(cal_success))
        else $error("command issued before calibration");
    bc4_gap_a: assert property (ce && rw_out && !r.addr[12] |=> !rw_out [*2])
        else $error("chopped burst not followed by two idle cycles");
    dqs_lead_a: assert property (ce && r.dqs == 2'h2 && !partial_wdv_off |=> r.wdv == 2'h3)
        else $error("write-valid does not follow strobe lead");
    ref_close_a: assert property (ref_out |-> !any_open)
        else $error("refresh with a bank open");
    rvalid_a: assert property (ce && local_rdata_valid |-> $past(phy_rdata_valid) == 2'h3)
        else $error("read valid without PHY valid");
endmodule // ddrc_ctrl

// ---- tb/ddrc_phy_model.sv ----
// Behavioural PHY side: calibration, latency counts and read return
`timescale 1ns/1ns
module ddrc_phy_model #(
    parameter int RLAT = 6,
    parameter int WLAT = 3,
    parameter int CAL_CYC = 30
) (
    // Clock and resets
    input wire logic clk,
    input wire logic reset,
    input wire logic soft_reset_n,
    // Handshake with the controller
    input wire logic [1:0] phy_doing_rd,
    output logic cal_success,
    output logic cal_fail,
    output logic [4:0] wlat,
    output logic [31:0] phy_rdata,
    output logic [1:0] phy_rdata_valid
);
    logic [2*RLAT-1:0] rd_pipe;
    int cal_cnt;
    logic [15:0] word_cnt;
    assign cal_fail = 1'b0;
    assign wlat = cal_success ? 5'(WLAT) : 5'h0;
    assign phy_rdata_valid = rd_pipe[2*RLAT-1 -: 2];
    always @(posedge clk or posedge reset) begin
        if (reset || !soft_reset_n) begin
            cal_cnt <= 0;
            cal_success <= 1'b0;
            rd_pipe <= '0;
            word_cnt <= 16'h0;
            phy_rdata <= 32'h0;
        end else begin
            cal_cnt <= cal_cnt + 1;
            if (cal_cnt == CAL_CYC) begin
                cal_success <= 1'b1;
            end
            rd_pipe <= {rd_pipe[2*RLAT-3:0], phy_doing_rd};
            if (rd_pipe[2*RLAT-3 -: 2] == 2'h3) begin
                phy_rdata <= {16'hc0de, word_cnt};
                word_cnt <= word_cnt + 16'h1;
            end else begin
                phy_rdata <= ~phy_rdata;
            end
        end
    end
endmodule // ddrc_phy_model

// ---- tb/ddrc_ctrl_test.sv ----
// Self-checking bench for the half-rate controller front end
`timescale 1ns/1ns
module ddrc_ctrl_test;
    localparam int WLAT = 3;
    logic clk, reset, local_read_req, local_write_req, local_autopch, refresh_req;
    logic cal_restart, cal_success, cal_fail, local_ready, local_wdata_req;
    logic local_rdata_valid, local_rd_busy, refresh_ack, soft_reset_n, partial_wdv_off;
    logic [24:0] local_addr;
    logic [1:0] local_size, phy_ras_n, phy_cas_n, phy_we_n, phy_doing_rd, phy_dqs_burst;
    logic [1:0] phy_wdata_valid, phy_rdata_valid, wv, prev_rd;
    logic [31:0] local_wdata, local_rdata, phy_wdata, phy_rdata, wbeat;
    logic [4:0] wlat;
    logic [3:0] phy_cs_n, phy_dm, local_be, dmv;
    logic [5:0] phy_ba;
    logic [25:0] phy_addr;
    logic [2:0] cmdq[$];
    int cycq[$];
    logic [31:0] rq[$], wq[$];
    int cyc = 0, fails = 0, n_compared = 0, n_rd11 = 0, wr_cyc = 0, cmd_cyc = 0, prev_cyc = 0;
    ddrc_ctrl dut (.clk(clk), .reset(reset), .ce(1'b1), .native_mode(1'b1),
        .partial_wdv_off(partial_wdv_off), .local_read_req(local_read_req),
        .local_write_req(local_write_req), .local_addr(local_addr), .local_size(local_size),
        .local_autopch(local_autopch), .local_wdata(local_wdata), .local_be(local_be),
        .local_ready(local_ready), .local_wdata_req(local_wdata_req),
        .local_rdata(local_rdata), .local_rdata_valid(local_rdata_valid),
        .local_rd_busy(local_rd_busy), .refresh_req(refresh_req), .refresh_ack(refresh_ack),
        .cal_success(cal_success), .cal_fail(cal_fail), .cal_restart(cal_restart),
        .wlat(wlat), .soft_reset_n(soft_reset_n), .phy_cs_n(phy_cs_n), .phy_ras_n(phy_ras_n),
        .phy_cas_n(phy_cas_n), .phy_we_n(phy_we_n), .phy_ba(phy_ba), .phy_addr(phy_addr),
        .phy_doing_rd(phy_doing_rd), .phy_dqs_burst(phy_dqs_burst),
        .phy_wdata_valid(phy_wdata_valid), .phy_wdata(phy_wdata), .phy_dm(phy_dm),
        .phy_rdata(phy_rdata), .phy_rdata_valid(phy_rdata_valid));
    ddrc_phy_model #(.WLAT(WLAT)) phy (.clk(clk), .reset(reset), .soft_reset_n(soft_reset_n),
        .phy_doing_rd(phy_doing_rd), .cal_success(cal_success), .cal_fail(cal_fail),
        .wlat(wlat), .phy_rdata(phy_rdata), .phy_rdata_valid(phy_rdata_valid));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // Command and write beat monitor on the PHY side, read words taken on the local side
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (phy_cs_n !== ddrc_pkg::CS_NONE) begin
            cmdq.push_back({phy_ras_n[0], phy_cas_n[0], phy_we_n[0]});
            cycq.push_back(cyc);
            chk("two_t", {phy_ras_n[1], phy_cas_n[1], phy_we_n[1]}, {phy_ras_n[0], phy_cas_n[0], phy_we_n[0]});
            chk("addr_halves", phy_addr[25:13], phy_addr[12:0]);
            if ({phy_ras_n[0], phy_cas_n[0], phy_we_n[0]} === ddrc_pkg::CMD_WR) wr_cyc = cyc;
            if ({phy_ras_n[0], phy_cas_n[0], phy_we_n[0]} === ddrc_pkg::CMD_RD) begin
                chk("read_lead", 32'h3, prev_rd);
            end
        end
        prev_rd = phy_doing_rd;
        if (phy_wdata_valid !== 2'h0) {wv, dmv} = {phy_wdata_valid, phy_dm};
        if (phy_dqs_burst === 2'h2) chk("write_latency", WLAT, cyc - wr_cyc);
        if (phy_wdata_valid === 2'h3) wq.push_back(phy_wdata);
        if (phy_doing_rd === 2'h3) n_rd11++;
        if (local_rdata_valid === 1'b1) rq.push_back(local_rdata);
        if (cyc > 2000) begin
            fails++;
            final_report();
        end
    end
    // Native write beats arrive the clock after each beat request
    always @(posedge clk) begin
        if (local_wdata_req === 1'b1) begin
            #1;
            local_wdata = wbeat;
            wbeat = wbeat + 32'h1;
        end
    end
    task automatic req(input logic wr, input logic [12:0] row, input logic [1:0] sz, input logic ap);
        int n;
        logic ok;
        n = 0;
        local_write_req = wr;
        local_read_req = !wr;
        local_addr = {1'b0, 3'h0, row, 8'h00};
        local_size = sz;
        local_autopch = ap;
        do begin
            ok = (local_ready === 1'b1);
            @(posedge clk);
            #1;
            n++;
        end while (!ok && n < 200);
        if (!ok) fails++;
    endtask
    task automatic idle();
        local_write_req = 1'b0;
        local_read_req = 1'b0;
    endtask
    task automatic next_cmd(input logic [2:0] exp);
        int n;
        n = 0;
        while (cmdq.size() == 0 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (cmdq.size() == 0) cmdq.push_back(3'h0);
        if (cycq.size() == 0) cycq.push_back(0);
        prev_cyc = cmd_cyc;
        cmd_cyc = cycq.pop_front();
        chk("command", exp, cmdq.pop_front());
    endtask
    initial begin
        {local_read_req, local_write_req, local_autopch, refresh_req, cal_restart} = 5'h0;
        local_addr = 25'h0;
        local_size = 2'h1;
        local_wdata = 32'h0;
        local_be = 4'hf;
        partial_wdv_off = 1'b0;
        wbeat = 32'h1111_0000;
        reset = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        reset = 1'b0;
        chk("cs_idle", ddrc_pkg::CS_NONE, phy_cs_n);
        for (int i = 0; i < 4; i++) req(1'b0, 13'h1, 2'h2, 1'b0);
        idle();
        chk("ready_full", 32'h0, local_ready);
        chk("early_cmds", 32'h0, cmdq.size());
        next_cmd(ddrc_pkg::CMD_ACT);
        repeat (4) next_cmd(ddrc_pkg::CMD_RD);
        chk("ready_back", 32'h1, local_ready);
        repeat (40) @(posedge clk);
        #1;
        chk("read_words", n_rd11, rq.size());
        for (int i = 0; i < rq.size(); i++) chk("read_data", {16'hc0de, 16'(i)}, rq[i]);
        $display("test queue and reads done");
        req(1'b1, 13'h2, 2'h1, 1'b0);
        req(1'b0, 13'h2, 2'h1, 1'b1);
        idle();
        next_cmd(ddrc_pkg::CMD_PCH);
        next_cmd(ddrc_pkg::CMD_ACT);
        next_cmd(ddrc_pkg::CMD_WR);
        next_cmd(ddrc_pkg::CMD_RD);
        chk("chop_gap", 32'h1, (cmd_cyc - prev_cyc) >= 3);
        repeat (30) @(posedge clk);
        #1;
        chk("write_beats", 32'h1, wq.size());
        chk("write_data", 32'h1111_0000, wq[0]);
        $display("test chopped write done");
        req(1'b0, 13'h2, 2'h2, 1'b0);
        idle();
        next_cmd(ddrc_pkg::CMD_ACT);
        next_cmd(ddrc_pkg::CMD_RD);
        repeat (20) @(posedge clk);
        #1;
        refresh_req = 1'b1;
        for (int n = 0; n < 50 && refresh_ack !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        refresh_req = 1'b0;
        chk("refresh_ack", 32'h1, refresh_ack);
        next_cmd(ddrc_pkg::CMD_PCH);
        next_cmd(ddrc_pkg::CMD_REF);
        $display("test refresh done");
        cal_restart = 1'b1;
        @(posedge clk);
        #1;
        chk("soft_reset", 32'h0, soft_reset_n);
        cal_restart = 1'b0;
        req(1'b0, 13'h2, 2'h2, 1'b0);
        idle();
        repeat (5) @(posedge clk);
        #1;
        chk("recal_cmds", 32'h0, cmdq.size());
        next_cmd(ddrc_pkg::CMD_ACT);
        next_cmd(ddrc_pkg::CMD_RD);
        $display("test recalibration done");
        partial_wdv_off = 1'b1;
        local_be = 4'h3;
        req(1'b1, 13'h2, 2'h1, 1'b0);
        idle();
        next_cmd(ddrc_pkg::CMD_WR);
        repeat (10) @(posedge clk);
        #1;
        chk("partial_wdv", 32'h1, wv);
        chk("partial_dm", 32'hc, dmv);
        $display("test partial write done");
        final_report();
    end
endmodule // ddrc_ctrl_test
